// file: common/ssf_pkg.sv
// Package of constants and carriers for the serial status flag logic.
package ssf_pkg;

  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [3:0] SSF_OFS_STATUS = 4'h0;
  localparam logic [3:0] SSF_OFS_DATA = 4'h4;
  localparam logic [3:0] SSF_OFS_CTRL = 4'h8;
  localparam logic [3:0] SSF_OFS_NINTH = 4'hc;

  // Flag positions in serial_status_one.
  localparam int SSF_F_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int SSF_F_TC = 6;
  localparam int SSF_F_RX_BUFFER_FULL_FLAG = 5;
  localparam int SSF_F_IDLE = 4;
  localparam int SSF_F_OR = 3;
  localparam int SSF_F_NF = 2;
  localparam int SSF_F_FE = 1;
  localparam int SSF_F_PF = 0;
  localparam logic [7:0] SSF_FLAGS_RST = 8'hc0;
  localparam logic [7:0] SSF_TX_MASK = 8'hc0;
  localparam logic [7:0] SSF_RX_MASK = 8'h3f;

  // Control register bit positions.
  localparam int SSF_C_BRK = 0;
  localparam int SSF_C_TXEN = 1;
  localparam int SSF_C_PAR = 2;
  localparam int SSF_C_ODD = 3;
  localparam int SSF_C_ILT = 4;
  localparam int SSF_C_NINE = 5;
  localparam int SSF_C_RIE = 6;
  localparam logic [6:0] SSF_CTRL_RST = 7'h00;

  // Ninth-bit register positions.
  localparam int SSF_N_R8 = 7;
  localparam int SSF_N_T8 = 6;

  // Idle thresholds in bit times for 8-bit and 9-bit characters.
  localparam logic [3:0] SSF_IDLE_BITS8 = 4'ha;
  localparam logic [3:0] SSF_IDLE_BITS9 = 4'hb;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ssf_av_req_s;

  // Avalon-MM answer to the master.
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ssf_av_rsp_s;

  // Events and levels from the receive shifter.
  typedef struct packed {
    logic sampleValid;
    logic sampleBit;
    logic bitDone;
    logic startDone;
    logic stopDone;
    logic bitTick;
    logic lineHigh;
    logic charDone;
    logic [8:0] charBits;
    logic stopBit;
  } ssf_rx_ev_s;

  // Events and levels from the transmit shifter.
  typedef struct packed {
    logic txLoad;
    logic txBusy;
  } ssf_tx_ev_s;

  // Controls towards the shifters.
  typedef struct packed {
    logic [8:0] txData;
    logic txFull;
    logic preamble;
    logic breakQueued;
    logic txEnable;
    logic nineBit;
    logic parityOn;
    logic parityOdd;
  } ssf_ctl_s;

endpackage : ssf_pkg

// file: verilog/ssf_noise_check.sv
// Sample disagreement detector that marks a received frame as noisy.
`timescale 1ns/10ps
module ssf_noise_check (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstN,
  // Sample stream.
  input wire logic sampleValid,
  input wire logic sampleBit,
  input wire logic bitDone,
  input wire logic charDone,
  // Result.
  output logic frameNoise
);

  // All state of the checker.
  typedef struct packed {
    logic haveFirst;
    logic firstVal;
    logic noise;
  } ssf_nc_state_s;

  ssf_nc_state_s stQ;
  ssf_nc_state_s stD;

  // The first sample of each bit is the reference; any later one that differs is noise.
  always_comb begin
    stD = stQ;
    if (sampleValid) begin
      if (!stQ.haveFirst) begin
        stD.haveFirst = 1'b1;
        stD.firstVal = sampleBit;
      end else if (sampleBit != stQ.firstVal) begin
        stD.noise = 1'b1;
      end
    end
    // A new bit time starts a fresh comparison.
    if (bitDone) begin
      stD.haveFirst = 1'b0;
    end
    // The result is consumed with the character, then the next frame starts clean.
    if (charDone) begin
      stD.noise = 1'b0;
      stD.haveFirst = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign frameNoise = stQ.noise;

endmodule : ssf_noise_check

// file: verilog/ssf_idle_counter.sv
// Idle-line bit-time counter that reports one full character time of mark.
`timescale 1ns/10ps
module ssf_idle_counter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstN,
  // Line timing.
  input wire logic bitTick,
  input wire logic lineHigh,
  input wire logic startDone,
  input wire logic stopDone,
  // Configuration.
  input wire logic afterStop,
  input wire logic nineBit,
  // Result.
  output logic idleSeen
);
  import ssf_pkg::*;

  // All state of the counter.
  typedef struct packed {
    logic [3:0] count;
    logic inFrame;
    logic seen;
  } ssf_ic_state_s;

  ssf_ic_state_s stQ;
  ssf_ic_state_s stD;
  logic [3:0] limit;

  // Count high bit times; a low bit restarts, the threshold fires once per run.
  always_comb begin
    stD = stQ;
    stD.seen = 1'b0;
    limit = nineBit ? SSF_IDLE_BITS9 : SSF_IDLE_BITS8;
    if (startDone) begin
      stD.inFrame = 1'b1;
    end
    if (stopDone) begin
      stD.inFrame = 1'b0;
      // Trailing ones of the frame must not count in this mode.
      if (afterStop) begin
        stD.count = 4'h0;
      end
    end
    if (bitTick) begin
      if (!lineHigh) begin
        stD.count = 4'h0;
      end else if ((!afterStop || !stQ.inFrame) && stQ.count < limit) begin
        stD.count = stQ.count + 4'h1;
        // Saturation at the limit keeps a long idle from firing twice.
        if (stQ.count + 4'h1 == limit) begin
          stD.seen = 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign idleSeen = stQ.seen;

endmodule : ssf_idle_counter

// file: verilog/ssf_status_flags.sv
// Status flag logic of the serial port with its Avalon-MM register slave.
//
// Behaviour
// - Eight read-only flags; status writes ignored.
// - Buffer-empty set at reset and on shifter load.
// - Complete set at reset and when transmitter idle.
// - Complete clears by read then write/enable/break.
// - Receive-full sets when character reaches data register.
// - Receive-full clears by status read, data read.
// - Idle sets after 10 or 11 high bits.
// - Idle select picks counting after start or stop.
// - Idle rearms only after a new character.
// - Idle clears by status read, data read.
// - Overrun when full; new character discarded.
// - Overrun clears by status read, data read.
// - Sample disagreement sets noise with receive-full.
// - Noise clears by status read, data read.
// - Low stop bit sets framing error.
// - Framing error clears by status read, data read.
// - Parity mismatch sets parity error when enabled.
// - Parity error clears by status read, data read.
// - Length setting selects eight or nine data bits.
// - Receive interrupt while enabled and receive-full set.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module ssf_status_flags (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register bus.
  input wire ssf_pkg::ssf_av_req_s avReq,
  output ssf_pkg::ssf_av_rsp_s avRsp,
  // Shifter events.
  input wire ssf_pkg::ssf_rx_ev_s rxEv,
  input wire ssf_pkg::ssf_tx_ev_s txEv,
  // Shifter controls and interrupt.
  output ssf_pkg::ssf_ctl_s ctl,
  output logic rxIrq
);
  import ssf_pkg::*;

  // All state of the block.
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] armed;
    logic [6:0] ctrl;
    logic [8:0] rxData;
    logic [8:0] txData;
    logic txT8;
    logic txFull;
    logic txPending;
    logic preamble;
    logic idleArmed;
    logic rxIrq;
    logic [31:0] readdata;
    logic waitreq;
  } ssf_state_s;

  ssf_state_s stQ;
  ssf_state_s stD;

  // Reset release chain; assertion is immediate, release takes two edges.
  logic rstMeta;
  logic rstN;

  // Helpers from the two small detectors.
  logic frameNoise;
  logic idleSeen;

  // Combinational helpers of the main process.
  logic [7:0] setF;
  logic [7:0] clrF;
  logic [31:0] rdVal;
  logic req;
  logic done;
  logic parExp;
  logic parGot;

  // Reset synchroniser; the first stage feeds only the second.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // Noise detector over the receiver's sample stream.
  ssf_noise_check uNoise (
    .clk(ref_clk),
    .rstN(rstN),
    .sampleValid(rxEv.sampleValid),
    .sampleBit(rxEv.sampleBit),
    .bitDone(rxEv.bitDone),
    .charDone(rxEv.charDone),
    .frameNoise(frameNoise)
  );

  // Idle-line counter.
  ssf_idle_counter uIdle (
    .clk(ref_clk),
    .rstN(rstN),
    .bitTick(rxEv.bitTick),
    .lineHigh(rxEv.lineHigh),
    .startDone(rxEv.startDone),
    .stopDone(rxEv.stopDone),
    .afterStop(stQ.ctrl[SSF_C_ILT]),
    .nineBit(stQ.ctrl[SSF_C_NINE]),
    .idleSeen(idleSeen)
  );

  // Next-state logic: bus slave, clearing sequences and flag setting.
  always_comb begin
    stD = stQ;
    stD.preamble = 1'b0;
    setF = 8'h00;
    clrF = 8'h00;
    rdVal = 32'h0000_0000;
    parExp = 1'b0;
    parGot = 1'b0;
    req = avReq.read | avReq.write;
    // The transfer completes on the edge where the master sees waitrequest low.
    done = req & ~stQ.waitreq;

    // Read mux; unmapped offsets read as zero.
    case (avReq.address)
      SSF_OFS_STATUS: begin
        rdVal = {24'h00_0000, stQ.flags};
      end
      SSF_OFS_DATA: begin
        rdVal = {24'h00_0000, stQ.rxData[7:0]};
      end
      SSF_OFS_CTRL: begin
        rdVal = {25'h000_0000, stQ.ctrl};
      end
      SSF_OFS_NINTH: begin
        rdVal = {24'h00_0000, stQ.rxData[8], stQ.txT8, 6'h00};
      end
      default: begin
        rdVal = 32'h0000_0000;
      end
    endcase

    // First cycle of a request: capture read data and drop waitrequest.
    if (req && stQ.waitreq) begin
      stD.waitreq = 1'b0;
      stD.readdata = rdVal;
    end

    // Completing cycle: side effects happen here and only here.
    if (done) begin
      stD.waitreq = 1'b1;
      if (avReq.read) begin
        case (avReq.address)
          SSF_OFS_STATUS: begin
            // Arm exactly the flags the reader was shown.
            stD.armed = stQ.readdata[7:0];
          end
          SSF_OFS_DATA: begin
            // Arms persist across other accesses until this data read.
            clrF = stQ.armed & SSF_RX_MASK;
            clrF = clrF | (stQ.armed & SSF_RX_MASK & 8'h07);
            stD.armed = stQ.armed & ~SSF_RX_MASK;
          end
          default: begin
          end
        endcase
      end else begin
        case (avReq.address)
          SSF_OFS_DATA: begin
            // A write without the armed sequence would overwrite a busy buffer, so it drops.
            if (stQ.armed[SSF_F_TX_BUFFER_EMPTY_FLAG]) begin
              stD.txData = {stQ.txT8, avReq.writedata[7:0]};
              stD.txFull = 1'b1;
              clrF[SSF_F_TX_BUFFER_EMPTY_FLAG] = 1'b1;
            end
            clrF[SSF_F_TC] = stQ.armed[SSF_F_TC];
            stD.armed = stQ.armed & ~SSF_TX_MASK;
          end
          SSF_OFS_CTRL: begin
            stD.ctrl = avReq.writedata[6:0];
            // Enable rising queues a preamble.
            if (!stQ.ctrl[SSF_C_TXEN] && avReq.writedata[SSF_C_TXEN]) begin
              stD.preamble = 1'b1;
              stD.txPending = 1'b1;
              clrF[SSF_F_TC] = stQ.armed[SSF_F_TC];
              stD.armed[SSF_F_TC] = 1'b0;
            end
            // Writing one to the break bit queues a break.
            if (avReq.writedata[SSF_C_BRK]) begin
              stD.txPending = 1'b1;
              clrF[SSF_F_TC] = stQ.armed[SSF_F_TC];
              stD.armed[SSF_F_TC] = 1'b0;
            end
          end
          SSF_OFS_NINTH: begin
            stD.txT8 = avReq.writedata[SSF_N_T8];
          end
          default: begin
            // Status writes and unmapped writes change nothing.
          end
        endcase
      end
    end

    // Shifter took the buffered value: buffer is free again.
    if (txEv.txLoad && stQ.txFull) begin
      stD.txFull = 1'b0;
      setF[SSF_F_TX_BUFFER_EMPTY_FLAG] = 1'b1;
    end

    // A queued action is held off until the shifter reports activity,
    // otherwise the complete flag would reappear in the gap before it starts.
    if (txEv.txBusy) begin
      stD.txPending = 1'b0;
    end

    // Idle transmitter with an empty buffer reports completion.
    // Judged on the state after this cycle's bus action, so a refill or a queued
    // preamble or break is not undone by a stale idle condition in the same cycle.
    if (stQ.flags[SSF_F_TX_BUFFER_EMPTY_FLAG] && !stD.txFull && !txEv.txBusy && !stD.txPending &&
        !stD.ctrl[SSF_C_BRK]) begin
      setF[SSF_F_TC] = 1'b1;
    end

    // Parity bit sits above the data bits; its place depends on length.
    if (stQ.ctrl[SSF_C_NINE]) begin
      parExp = ^rxEv.charBits[7:0];
      parGot = rxEv.charBits[8];
    end else begin
      parExp = ^rxEv.charBits[6:0];
      parGot = rxEv.charBits[7];
    end
    parExp = parExp ^ stQ.ctrl[SSF_C_ODD];

    // New character from the receive shifter.
    if (rxEv.charDone) begin
      if (stQ.flags[SSF_F_RX_BUFFER_FULL_FLAG]) begin
        // Old character unread: keep it and drop the new one with its errors.
        setF[SSF_F_OR] = 1'b1;
      end else begin
        stD.rxData = stQ.ctrl[SSF_C_NINE] ? rxEv.charBits : {1'b0, rxEv.charBits[7:0]};
        setF[SSF_F_RX_BUFFER_FULL_FLAG] = 1'b1;
        setF[SSF_F_NF] = frameNoise;
        setF[SSF_F_FE] = ~rxEv.stopBit;
        setF[SSF_F_PF] = stQ.ctrl[SSF_C_PAR] & (parExp != parGot);
        stD.idleArmed = 1'b1;
      end
    end

    // Idle sets once, then waits for the next received character.
    if (idleSeen && stQ.idleArmed) begin
      setF[SSF_F_IDLE] = 1'b1;
      stD.idleArmed = 1'b0;
    end

    // Set wins over clear in the same cycle; bus writes only clear flags, never set them.
    stD.flags = (stQ.flags & ~clrF) | setF;

    // Level interrupt follows the receive-full flag.
    stD.rxIrq = stD.ctrl[SSF_C_RIE] & stD.flags[SSF_F_RX_BUFFER_FULL_FLAG];
  end

  // State register; flags come up with the transmit side empty and complete.
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stQ.flags <= SSF_FLAGS_RST;
      stQ.armed <= 8'h00;
      stQ.ctrl <= SSF_CTRL_RST;
      stQ.rxData <= 9'h000;
      stQ.txData <= 9'h000;
      stQ.txT8 <= 1'b0;
      stQ.txFull <= 1'b0;
      stQ.txPending <= 1'b0;
      stQ.preamble <= 1'b0;
      stQ.idleArmed <= 1'b0;
      stQ.rxIrq <= 1'b0;
      stQ.readdata <= 32'h0000_0000;
      stQ.waitreq <= 1'b1;
    end else begin
      stQ <= stD;
    end
  end

  // Outputs straight from the state flip-flops.
  assign avRsp.readdata = stQ.readdata;
  assign avRsp.waitrequest = stQ.waitreq;
  assign ctl.txData = stQ.txData;
  assign ctl.txFull = stQ.txFull;
  assign ctl.preamble = stQ.preamble;
  assign ctl.breakQueued = stQ.ctrl[SSF_C_BRK];
  assign ctl.txEnable = stQ.ctrl[SSF_C_TXEN];
  assign ctl.nineBit = stQ.ctrl[SSF_C_NINE];
  assign ctl.parityOn = stQ.ctrl[SSF_C_PAR];
  assign ctl.parityOdd = stQ.ctrl[SSF_C_ODD];
  assign rxIrq = stQ.rxIrq;

endmodule : ssf_status_flags

// file: verification/ssf_status_props.sv
// Port-level assertions for the serial status flag logic.
`timescale 1ns/10ps
module ssf_status_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register bus.
  input wire ssf_pkg::ssf_av_req_s avReq,
  input wire ssf_pkg::ssf_av_rsp_s avRsp,
  // Shifter side.
  input wire ssf_pkg::ssf_rx_ev_s rxEv,
  input wire ssf_pkg::ssf_tx_ev_s txEv,
  input wire ssf_pkg::ssf_ctl_s ctl,
  input wire logic rxIrq
);
  import ssf_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // A transfer completes at the edge where the slave shows waitrequest low.
  sequence s_done(logic [3:0] a, logic w);
    !avRsp.waitrequest && avReq.address == a && (w ? avReq.write : avReq.read);
  endsequence

  // A CTRL write that turns the transmitter on.
  sequence s_tx_on;
    !avRsp.waitrequest && avReq.write && avReq.address == SSF_OFS_CTRL
      && avReq.writedata[SSF_C_TXEN] && !ctl.txEnable;
  endsequence

  a_wait_answer: assert property ((avReq.read || avReq.write) && avRsp.waitrequest
    |=> !avRsp.waitrequest) else $error("waitrequest not dropped");
  a_wait_single: assert property (!avRsp.waitrequest |=> avRsp.waitrequest)
    else $error("waitrequest low too long");
  a_status_eight: assert property (s_done(SSF_OFS_STATUS, 1'b0)
    |-> avRsp.readdata[31:8] == 24'h0) else $error("status wider than eight");
  a_unmapped_zero: assert property (avReq.read && !avRsp.waitrequest
    && avReq.address[1:0] != 2'b00 |-> avRsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  a_load_empties: assert property (txEv.txLoad && ctl.txFull |=> !ctl.txFull)
    else $error("buffer kept after load");
  a_full_cause: assert property ($rose(ctl.txFull)
    |-> $past(!avRsp.waitrequest && avReq.write && avReq.address == SSF_OFS_DATA))
    else $error("buffer filled without data write");
  a_full_data: assert property (s_done(SSF_OFS_DATA, 1'b1) ##1 $rose(ctl.txFull)
    |-> ctl.txData[7:0] == $past(avReq.writedata[7:0]))
    else $error("buffered byte wrong");
  a_preamble_cause: assert property ($rose(ctl.preamble) |-> $past(!avRsp.waitrequest
    && avReq.write && avReq.address == SSF_OFS_CTRL && avReq.writedata[SSF_C_TXEN]
    && !ctl.txEnable)) else $error("preamble without enable rise");
  a_preamble_pulse: assert property (s_tx_on |=> ctl.preamble ##1 !ctl.preamble)
    else $error("preamble not one pulse");
  a_ctrl_follow: assert property (s_done(SSF_OFS_CTRL, 1'b1) |=>
    ctl.parityOn == $past(avReq.writedata[SSF_C_PAR])
    && ctl.nineBit == $past(avReq.writedata[SSF_C_NINE])
    && ctl.breakQueued == $past(avReq.writedata[SSF_C_BRK])
    && ctl.parityOdd == $past(avReq.writedata[SSF_C_ODD]))
    else $error("control levels wrong");
endmodule : ssf_status_props

bind ssf_status_flags ssf_status_props i_props (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .avReq(avReq),
  .avRsp(avRsp),
  .rxEv(rxEv),
  .txEv(txEv),
  .ctl(ctl),
  .rxIrq(rxIrq)
);

// file: verification/ssf_far_end.sv
// Behavioural model of the receive and transmit shifters.
`timescale 1ns/10ps
module ssf_far_end (
  // Clock.
  input wire logic clk,
  // Shifter events.
  output ssf_pkg::ssf_rx_ev_s rxEv,
  output ssf_pkg::ssf_tx_ev_s txEv
);
  import ssf_pkg::*;

  // Both shifters start quiet.
  initial begin
    rxEv = '0;
    txEv = '0;
  end

  // One frame: start, eight data bits, stop; three samples a bit.
  task automatic send_char(input logic [7:0] d, input logic stp, input logic nz);
    logic lv;
    for (int b = 0; b < 10; b++) begin
      lv = (b == 0) ? 1'b0 : (b == 9) ? stp : d[(b + 7) % 8];
      for (int s = 0; s < 3; s++) begin
        @(posedge clk);
        rxEv.sampleValid <= 1'b1;
        rxEv.sampleBit <= lv ^ (nz && b == 4 && s == 1);
      end
      @(posedge clk);
      rxEv.sampleValid <= 1'b0;
      rxEv.sampleBit <= ~lv;
      rxEv.bitDone <= 1'b1;
      rxEv.bitTick <= 1'b1;
      rxEv.lineHigh <= lv;
      rxEv.startDone <= (b == 0);
      rxEv.stopDone <= (b == 9);
      @(posedge clk);
      rxEv.bitDone <= 1'b0;
      rxEv.bitTick <= 1'b0;
      rxEv.startDone <= 1'b0;
      rxEv.stopDone <= 1'b0;
    end
    // The character is offered one cycle after its last bit ends.
    rxEv.charBits <= {1'b0, d};
    rxEv.stopBit <= stp;
    rxEv.charDone <= 1'b1;
    @(posedge clk);
    rxEv.charDone <= 1'b0;
    rxEv.charBits <= ~{1'b0, d};
    rxEv.stopBit <= ~stp;
  endtask : send_char

  // Bit times of mark line after a frame.
  task automatic idle_ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      rxEv.bitTick <= 1'b1;
      rxEv.lineHigh <= 1'b1;
      @(posedge clk);
      rxEv.bitTick <= 1'b0;
    end
  endtask : idle_ticks

  // The transmit shifter starts sending, taking the buffer if asked.
  task automatic tx_go(input logic load);
    @(posedge clk);
    txEv.txLoad <= load;
    txEv.txBusy <= 1'b1;
    @(posedge clk);
    txEv.txLoad <= 1'b0;
  endtask : tx_go

  // The transmit shifter falls idle.
  task automatic tx_end();
    repeat (3) @(posedge clk);
    txEv.txBusy <= 1'b0;
  endtask : tx_end
endmodule : ssf_far_end

// file: verification/tb.sv
// Self-checking bench for the serial status flag logic.
`timescale 1ns/10ps
module tb;
  import ssf_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  ssf_av_req_s avReq = '0;
  ssf_av_rsp_s avRsp;
  ssf_rx_ev_s rxEv;
  ssf_tx_ev_s txEv;
  ssf_ctl_s ctl;
  logic rxIrq;
  int fails = 0;
  int num_checks = 0;

  ssf_status_flags i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .avReq(avReq),
    .avRsp(avRsp), .rxEv(rxEv), .txEv(txEv), .ctl(ctl), .rxIrq(rxIrq));
  ssf_far_end i_far (.clk(ref_clk), .rxEv(rxEv), .txEv(txEv));

  // Free-running 125 MHz clock.
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Compares one value; unknown bits never match.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // One Avalon-MM transfer, held until waitrequest is seen low.
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avReq <= '{a, !w, w, wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avRsp.waitrequest !== 1'b0 && n < 40);
    if (avRsp.waitrequest !== 1'b0) begin
      fails++;
      report_and_stop();
    end
    rd = avRsp.readdata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
  endtask : bus

  // Register read with an expected byte.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    chk($sformatf("reg_%h", a), {24'h0, e}, v);
  endtask : rd

  // Register write of one byte.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] v;
    bus(a, 1'b1, {24'h0, d}, v);
  endtask : wr

  // Receive a frame, check the flags, then run the clearing reads.
  task automatic rx_case(input logic [7:0] d, input logic stp, input logic nz,
      input logic [7:0] st);
    i_far.send_char(d, stp, nz);
    rd(4'h0, st);
    rd(4'h4, d);
    rd(4'h0, 8'hc0);
  endtask : rx_case

  // Main sequence; each step leaves the flags at their idle value.
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(4'h0, 8'hc0);
    rd(4'h8, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'hc0);
    // Data write empties nothing until the shifter takes the byte.
    rd(4'h0, 8'hc0);
    wr(4'h4, 8'ha5);
    rd(4'h0, 8'h00);
    chk("txData", 32'ha5, {23'h0, ctl.txData});
    i_far.tx_go(1'b1);
    rd(4'h0, 8'h80);
    i_far.tx_end();
    rd(4'h0, 8'hc0);
    // Preamble and break both hold off completion.
    rd(4'h0, 8'hc0);
    wr(4'h8, 8'h02);
    rd(4'h0, 8'h80);
    i_far.tx_go(1'b0);
    i_far.tx_end();
    rd(4'h0, 8'hc0);
    wr(4'h8, 8'h03);
    rd(4'h0, 8'h80);
    wr(4'h8, 8'h02);
    i_far.tx_go(1'b0);
    i_far.tx_end();
    rd(4'h0, 8'hc0);
    // Ninth transmit bit rides along with the next data write.
    wr(4'hc, 8'h40);
    rd(4'hc, 8'h40);
    wr(4'h4, 8'h5a);
    rd(4'h0, 8'h00);
    chk("txData9", 32'h15a, {23'h0, ctl.txData});
    i_far.tx_go(1'b1);
    i_far.tx_end();
    wr(4'hc, 8'h00);
    // Clean frame, framing error, noise, even parity error and match, odd parity match.
    rx_case(8'h81, 1'b1, 1'b0, 8'he0);
    rx_case(8'h3c, 1'b0, 1'b0, 8'he2);
    rx_case(8'h0f, 1'b1, 1'b1, 8'he4);
    wr(4'h8, 8'h04);
    rx_case(8'h01, 1'b1, 1'b0, 8'he1);
    rx_case(8'h81, 1'b1, 1'b0, 8'he0);
    wr(4'h8, 8'h0c);
    rx_case(8'h01, 1'b1, 1'b0, 8'he0);
    wr(4'h8, 8'h00);
    // Overrun keeps the first byte and drops the second with its error.
    i_far.send_char(8'h11, 1'b1, 1'b0);
    i_far.send_char(8'h22, 1'b0, 1'b0);
    rx_case(8'h11, 1'b1, 1'b0, 8'he8);
    // A frame after the status read is not cleared; the interrupt follows it.
    rd(4'h0, 8'hc0);
    i_far.send_char(8'h33, 1'b1, 1'b0);
    wr(4'h8, 8'h40);
    @(posedge ref_clk);
    chk("rxIrq", 32'h1, {31'h0, rxIrq});
    rd(4'h4, 8'h33);
    rd(4'h0, 8'he0);
    rd(4'h8, 8'h40);
    rd(4'h4, 8'h33);
    @(posedge ref_clk);
    chk("rxIrq", 32'h0, {31'h0, rxIrq});
    // Idle from after the start bit, then from after the stop bit.
    for (int k = 0; k < 2; k++) begin
      wr(4'h8, k ? 8'h10 : 8'h00);
      rx_case(k ? 8'hff : 8'h55, 1'b1, 1'b0, 8'he0);
      i_far.idle_ticks(k ? 9 : 8);
      rd(4'h0, 8'hc0);
      i_far.idle_ticks(1);
      rd(4'h0, 8'hd0);
      rd(4'h4, k ? 8'hff : 8'h55);
      rd(4'h0, 8'hc0);
    end
    // Nine-bit characters need eleven high bit times.
    wr(4'h8, 8'h20);
    rx_case(8'h55, 1'b1, 1'b0, 8'he0);
    i_far.idle_ticks(9);
    rd(4'h0, 8'hc0);
    i_far.idle_ticks(1);
    rd(4'h0, 8'hd0);
    rd(4'h4, 8'h55);
    i_far.idle_ticks(12);
    rd(4'h0, 8'hc0);
    report_and_stop();
  end
endmodule : tb
